// ===== bench/blwm_ctrl_model.sv
/* memory controller model driving the write port pins.
   assumes the bench calls burst; k and k_n stand low between frames. */
`timescale 1ns/1ps
`default_nettype none
module blwm_ctrl_model
  import blwm_pkg::*;
(
  output var blwm_pins_s pins
);
  initial begin
    pins = '0;
    pins.write_port_select_n = 1'b1;
    pins.lane_write_select_n = 4'hf;
  end
  // one link rise, a quarter period of set-up and of hold around it
  task automatic rise(input logic tk);
    #31.25;
    pins.k = tk;
    pins.k_n = !tk;
    #31.25;
  endtask
  task automatic burst(input logic [3:0] a, input logic [35:0] d [4],
                       input logic [3:0] s [4], input logic dbl);
    pins.write_port_select_n = 1'b0;
    pins.addr = a;
    rise(1'b1);
    pins.addr = ~a;
    pins.write_port_select_n = !dbl;
    rise(1'b0);
    for (int b = 0; b < 4; b++) begin
      pins.lane_write_select_n = s[b];
      pins.data = d[b];
      rise(b % 2 == 0);
      pins.write_port_select_n = 1'b1;
    end
    pins.data = ~pins.data;
    pins.lane_write_select_n = ~pins.lane_write_select_n;
    pins.k_n = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== bench/blwm_write_port_properties.sv
/* checker of the lane-masked write port status outputs.
   assumes pin edges reach beat_done within four clock edges. */
`timescale 1ns/1ps
`default_nettype none
module blwm_write_port_props (
  input wire logic clock,
  input wire logic nrst,
  input wire logic lane0_write_select_n,
  input wire logic lane1_write_select_n,
  input wire logic lane2_write_select_n,
  input wire logic lane3_write_select_n,
  input wire logic write_busy,
  input wire logic write_pending,
  input wire logic beat_done,
  input wire logic [3:0] beat_lane_en,
  input wire logic [5:0] beat_loc,
  input wire logic request_dropped
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic [3:0] sel_n;
  logic [5:0] prev_loc_r;
  logic [5:0] prev_loc_nxt;
  assign sel_n = {lane3_write_select_n, lane2_write_select_n,
                  lane1_write_select_n, lane0_write_select_n};
  always_comb prev_loc_nxt = beat_done ? beat_loc : prev_loc_r;
  always_ff @(posedge clock) prev_loc_r <= nrst ? prev_loc_nxt : 6'h0;
  ////////////////////////////////////////
  all_low_a: assert property (beat_done && $past(sel_n, 4) == 4'h0
    |-> beat_lane_en == 4'hf) else $error("full word not written");
  all_high_a: assert property (beat_done && $past(sel_n, 4) == 4'hf
    |-> beat_lane_en == 4'h0) else $error("masked beat wrote a lane");
  lane_map_a: assert property (beat_done
    |-> beat_lane_en == ~$past(sel_n, 4)) else $error("lane enables wrong");
  done_pulse_a: assert property (beat_done |=> !beat_done)
    else $error("beat pulse too long");
  beat_order_a: assert property (beat_done && beat_loc[1:0] != 2'h0
    |-> beat_loc == prev_loc_r + 6'h1) else $error("beat location out of order");
  beat_gap_a: assert property (beat_done && beat_loc[1:0] != 2'h3
    |=> ##[4:8] beat_done) else $error("next beat missing");
  burst_end_a: assert property (beat_done && beat_loc[1:0] == 2'h3
    |-> ##[0:1] !write_busy) else $error("busy after last beat");
  pend_start_a: assert property ($fell(write_pending) |-> write_busy)
    else $error("pending cleared without burst");
  drop_pulse_a: assert property (request_dropped |=> !request_dropped)
    else $error("drop pulse too long");
  reset_quiet_a: assert property (disable iff (1'b0) !nrst |=> !write_busy
    && !write_pending && !beat_done && !request_dropped) else $error("status set in reset");
  cover property (beat_done && beat_lane_en == 4'hf);
  cover property (beat_done && beat_lane_en == 4'h0);
  cover property (request_dropped);
endmodule
bind blwm_write_port blwm_write_port_props u_props (.clock, .nrst,
  .lane0_write_select_n, .lane1_write_select_n, .lane2_write_select_n,
  .lane3_write_select_n, .write_busy, .write_pending, .beat_done,
  .beat_lane_en, .beat_loc, .request_dropped);
`default_nettype wire

// ===== bench/byte_lane_write_mask_x36_tb_top.sv
/* self-checking bench of the lane-masked write port.
   assumes the controller model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module byte_lane_write_mask_x36_tb_top;
  import blwm_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic rd_en = 1'b0;
  logic drop_seen = 1'b0;
  logic request_dropped;
  logic write_busy;
  logic write_pending;
  logic [3:0] beat_lane_en;
  logic [5:0] beat_loc;
  logic [5:0] rd_loc = 6'h0;
  logic [35:0] rd_data;
  logic [35:0] exp_mem [64];
  blwm_pins_s pins;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  always #5 clock = ~clock;
  blwm_ctrl_model u_ctrl (.pins);
  blwm_write_port u_dut (.clock, .nrst, .k(pins.k), .k_n(pins.k_n),
    .write_port_select_n(pins.write_port_select_n),
    .lane0_write_select_n(pins.lane_write_select_n[0]),
    .lane1_write_select_n(pins.lane_write_select_n[1]),
    .lane2_write_select_n(pins.lane_write_select_n[2]),
    .lane3_write_select_n(pins.lane_write_select_n[3]),
    .addr(pins.addr), .data(pins.data), .rd_en, .rd_loc, .rd_data,
    .write_busy, .write_pending, .beat_done(), .beat_lane_en,
    .beat_loc, .request_dropped);
  ////////////////////////////////////////
  always @(posedge clock) begin
    cycles++;
    if (request_dropped === 1'b1) drop_seen = 1'b1;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic read_loc(input logic [5:0] loc, output logic [35:0] v);
    @(posedge clock);
    rd_en <= 1'b1;
    rd_loc <= loc;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 v = rd_data;
  endtask
  // burst, update the expected array lane by lane, read all four back
  task automatic burst_chk(input string nm, input logic [3:0] a,
      input logic [35:0] d [4], input logic [3:0] s [4], input logic dbl);
    logic [35:0] v;
    drop_seen = 1'b0;
    u_ctrl.burst(a, d, s, dbl);
    for (int b = 0; b < 4; b++)
      for (int l = 0; l < 4; l++)
        if (!s[b][l]) exp_mem[{a, 2'(b)}][9*l +: 9] = d[b][9*l +: 9];
    repeat (10) @(posedge clock);
    for (int b = 0; b < 4; b++) begin
      read_loc({a, 2'(b)}, v);
      check(v, exp_mem[{a, 2'(b)}]);
    end
    check({32'h0, beat_lane_en}, {32'h0, ~s[3]});
    check({30'h0, beat_loc}, {30'h0, a, 2'h3});
    check({34'h0, write_busy, write_pending}, 36'h0);
    check({35'h0, drop_seen}, {35'h0, dbl});
    $display("test %s done", nm);
  endtask
  ////////////////////////////////////////
  task automatic t_full;
    burst_chk("full", 4'h1, '{36'h123456789, 36'h9abcdef01, 36'h0f0f0f0f0,
      36'hfedcba987}, '{4'h0, 4'h0, 4'h0, 4'h0}, 1'b0);
  endtask
  task automatic t_lanes;
    burst_chk("lanes", 4'h1, '{36'haaaaaaaaa, 36'h555555555, 36'hfffffffff,
      36'h000000000}, '{4'he, 4'hd, 4'hb, 4'h7}, 1'b0);
  endtask
  task automatic t_mixed;
    burst_chk("mixed", 4'h1, '{36'h111111111, 36'h222222222, 36'h333333333,
      36'h444444444}, '{4'hf, 4'h5, 4'ha, 4'hf}, 1'b0);
  endtask
  task automatic t_drop;
    burst_chk("drop", 4'hf, '{36'h876543210, 36'h13579bdf0, 36'h2468ace13,
      36'hc3c3c3c3c}, '{4'h0, 4'h0, 4'h0, 4'h0}, 1'b1);
  endtask
  initial begin
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    repeat (4) @(posedge clock);
    t_full();
    t_lanes();
    t_mixed();
    t_drop();
    stop_test();
  end
endmodule
`default_nettype wire

// ===== verilog/blwm_consts.svh
/*
  constants of the lane-masked write port: widths, lane layout, burst shape.
  assumes inclusion by bare name from package and modules.
*/
`ifndef BLWM_CONSTS_SVH
`define BLWM_CONSTS_SVH

`define BLWM_DATA_W 36
`define BLWM_LANE_W 9
`define BLWM_LANES 4
`define BLWM_ADDR_W 4
`define BLWM_BEATS 4
`define BLWM_BEAT_W 2
`define BLWM_LOC_W 6
`define BLWM_DEPTH 64
`define BLWM_LANE0_LSB 0
`define BLWM_LANE1_LSB 9
`define BLWM_LANE2_LSB 18
`define BLWM_LANE3_LSB 27
`define BLWM_SEL_IDLE 4'hf
`define BLWM_BEAT_FIRST 2'h0
`define BLWM_BEAT_LAST 2'h3
`define BLWM_PIN_W 47

`endif

// ===== verilog/blwm_lane_mem.sv
/*
  burst location array with one write enable per 9-bit lane.
  assumes single clock; read data registered, one cycle after rd_en.
*/
`timescale 1ns/1ps
`default_nettype none
`include "blwm_consts.svh"

module blwm_lane_mem
  import blwm_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire blwm_beat_s wr,
  input wire logic rd_en,
  input wire logic [`BLWM_LOC_W-1:0] rd_loc,
  output logic [`BLWM_DATA_W-1:0] rd_data
);

  logic [`BLWM_LANES-1:0][`BLWM_LANE_W-1:0] rd_lanes;
  logic [`BLWM_DATA_W-1:0] rd_data_r;
  logic [`BLWM_DATA_W-1:0] rd_data_nxt;

  ////////////////////////////////////////////////////////////////////////
  // per-lane array: one writer each, a lane with enable low keeps its bits
  for (genvar i = 0; i < `BLWM_LANES; i++) begin : g_lane
    logic [`BLWM_LANE_W-1:0] lane_mem [`BLWM_DEPTH];
    always_ff @(posedge clock) begin
      if (wr.lane_en[i]) begin
        lane_mem[wr.loc] <= wr.data[i*`BLWM_LANE_W +: `BLWM_LANE_W];
      end
    end
    assign rd_lanes[i] = lane_mem[rd_loc];
  end

  ////////////////////////////////////////////////////////////////////////
  // registered read
  always_comb begin
    rd_data_nxt = rd_data_r;
    if (!nrst) begin
      rd_data_nxt = '0;
    end else if (rd_en) begin
      rd_data_nxt = rd_lanes;
    end
  end

  always_ff @(posedge clock) begin
    rd_data_r <= rd_data_nxt;
  end

  assign rd_data = rd_data_r;

endmodule

`default_nettype wire

// ===== verilog/blwm_pkg.sv
/*
  types of the lane-masked write port.
  assumes blwm_consts.svh on the include path.
*/
`include "blwm_consts.svh"

package blwm_pkg;

  // pin bundle as seen by the sampling clock
  typedef struct packed {
    logic k;
    logic k_n;
    logic write_port_select_n;
    logic [`BLWM_LANES-1:0] lane_write_select_n;
    logic [`BLWM_ADDR_W-1:0] addr;
    logic [`BLWM_DATA_W-1:0] data;
  } blwm_pins_s;

  // one beat handed to the array
  typedef struct packed {
    logic [`BLWM_LANES-1:0] lane_en;
    logic [`BLWM_LOC_W-1:0] loc;
    logic [`BLWM_DATA_W-1:0] data;
  } blwm_beat_s;

  typedef enum logic {
    BLWM_IDLE,
    BLWM_BURST
  } blwm_state_e;

endpackage

// ===== verilog/blwm_sync.sv
/*
  two-flop synchroniser for a bundle of pins.
  assumes pins are asynchronous to clock; reset value is a parameter.
*/
`timescale 1ns/1ps
`default_nettype none

module blwm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  always_comb begin
    meta_nxt = nrst ? async_in : RST;
    sync_nxt = nrst ? meta_r : RST;
  end

  always_ff @(posedge clock) begin
    meta_r <= meta_nxt;
    sync_r <= sync_nxt;
  end

  assign sync_out = sync_r;

endmodule

`default_nettype wire

// ===== verilog/blwm_write_port.sv
/*
  write port of a burst-of-four double-rate sram, x36 with four lane selects.
  assumes k and k_n arrive from the controller asynchronously to clock and
  are slow enough (125 ns period) to be sampled and edge-detected here.
*/
// What this block does
// - all four selectors low on a beat stores the whole 36-bit word.
// - only selector zero low updates bits 8:0, others kept.
// - only selector one low updates bits 17:9, others kept.
// - only selector two low updates bits 26:18, others kept.
// - only selector three low updates bits 35:27, others kept.
// - all selectors high leaves the beat's location unchanged; burst continues.
// - selectors sampled separately on every k and k_n rise of data phase.
// - write requests on consecutive k rises not allowed; second is ignored.
`timescale 1ns/1ps
`default_nettype none
`include "blwm_consts.svh"

module blwm_write_port
  import blwm_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic k,
  input wire logic k_n,
  input wire logic write_port_select_n,
  input wire logic lane0_write_select_n,
  input wire logic lane1_write_select_n,
  input wire logic lane2_write_select_n,
  input wire logic lane3_write_select_n,
  input wire logic [`BLWM_ADDR_W-1:0] addr,
  input wire logic [`BLWM_DATA_W-1:0] data,
  input wire logic rd_en,
  input wire logic [`BLWM_LOC_W-1:0] rd_loc,
  output logic [`BLWM_DATA_W-1:0] rd_data,
  output logic write_busy,
  output logic write_pending,
  output logic beat_done,
  output logic [`BLWM_LANES-1:0] beat_lane_en,
  output logic [`BLWM_LOC_W-1:0] beat_loc,
  output logic request_dropped
);

  ////////////////////////////////////////////////////////////////////////
  // pin sampling

  blwm_pins_s pins_raw;
  blwm_pins_s pins_s;

  localparam blwm_pins_s PINS_RST = '{
    k: 1'b0,
    k_n: 1'b0,
    write_port_select_n: 1'b1,
    lane_write_select_n: `BLWM_SEL_IDLE,
    addr: '0,
    data: '0
  };

  always_comb begin
    pins_raw.k = k;
    pins_raw.k_n = k_n;
    pins_raw.write_port_select_n = write_port_select_n;
    pins_raw.lane_write_select_n = {lane3_write_select_n, lane2_write_select_n,
                                    lane1_write_select_n, lane0_write_select_n};
    pins_raw.addr = addr;
    pins_raw.data = data;
  end

  // data, selects and clocks cross together so they stay aligned
  blwm_sync #(
    .W(`BLWM_PIN_W),
    .RST(PINS_RST)
  ) u_sync (
    .clock(clock),
    .nrst(nrst),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // edge detection on the sampled link clocks

  logic k_d_r;
  logic k_d_nxt;
  logic kn_d_r;
  logic kn_d_nxt;
  logic k_rise;
  logic kn_rise;

  always_comb begin
    k_d_nxt = nrst ? pins_s.k : 1'b0;
    kn_d_nxt = nrst ? pins_s.k_n : 1'b0;
  end

  always_ff @(posedge clock) begin
    k_d_r <= k_d_nxt;
    kn_d_r <= kn_d_nxt;
  end

  assign k_rise = pins_s.k & ~k_d_r;
  assign kn_rise = pins_s.k_n & ~kn_d_r;

  ////////////////////////////////////////////////////////////////////////
  // request acceptance

  logic prev_req_r;
  logic prev_req_nxt;
  logic pend_v_r;
  logic pend_v_nxt;
  logic [`BLWM_ADDR_W-1:0] pend_addr_r;
  logic [`BLWM_ADDR_W-1:0] pend_addr_nxt;
  logic req_seen;
  logic req_take;
  logic req_drop;
  logic start_burst;

  assign req_seen = k_rise & ~pins_s.write_port_select_n;
  // a request right after one on the previous k rise is thrown away
  assign req_take = req_seen & ~prev_req_r;
  assign req_drop = req_seen & prev_req_r;

  always_comb begin
    prev_req_nxt = prev_req_r;
    pend_v_nxt = pend_v_r;
    pend_addr_nxt = pend_addr_r;
    if (!nrst) begin
      prev_req_nxt = 1'b0;
      pend_v_nxt = 1'b0;
      pend_addr_nxt = '0;
    end else if (k_rise) begin
      prev_req_nxt = ~pins_s.write_port_select_n;
      if (start_burst) begin
        pend_v_nxt = 1'b0;
      end
      if (req_take) begin
        // beats begin on the next k rise, so the address waits here
        pend_v_nxt = 1'b1;
        pend_addr_nxt = pins_s.addr;
      end
    end
  end

  always_ff @(posedge clock) begin
    prev_req_r <= prev_req_nxt;
    pend_v_r <= pend_v_nxt;
    pend_addr_r <= pend_addr_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // burst sequencer: beats on k, k_n, k, k_n

  blwm_state_e state_r;
  blwm_state_e state_nxt;
  logic [`BLWM_ADDR_W-1:0] cur_addr_r;
  logic [`BLWM_ADDR_W-1:0] cur_addr_nxt;
  logic [`BLWM_BEAT_W-1:0] beat_r;
  logic [`BLWM_BEAT_W-1:0] beat_nxt;
  logic beat_now;
  logic [`BLWM_ADDR_W-1:0] beat_addr;
  logic [`BLWM_BEAT_W-1:0] beat_idx;

  // a pending address opens its burst on the first k rise after capture
  assign start_burst = (state_r == BLWM_IDLE) & k_rise & pend_v_r;

  always_comb begin
    state_nxt = state_r;
    cur_addr_nxt = cur_addr_r;
    beat_nxt = beat_r;
    beat_now = 1'b0;
    beat_addr = cur_addr_r;
    beat_idx = beat_r;
    if (!nrst) begin
      state_nxt = BLWM_IDLE;
      cur_addr_nxt = '0;
      beat_nxt = `BLWM_BEAT_FIRST;
    end else begin
      case (state_r)
        BLWM_IDLE: begin
          if (start_burst) begin
            beat_now = 1'b1;
            beat_addr = pend_addr_r;
            beat_idx = `BLWM_BEAT_FIRST;
            cur_addr_nxt = pend_addr_r;
            beat_nxt = `BLWM_BEAT_FIRST + 2'h1;
            state_nxt = BLWM_BURST;
          end
        end
        BLWM_BURST: begin
          // even beats on k, odd beats on k_n
          if ((k_rise & ~beat_r[0]) | (kn_rise & beat_r[0])) begin
            beat_now = 1'b1;
            beat_nxt = beat_r + 2'h1;
            if (beat_r == `BLWM_BEAT_LAST) begin
              state_nxt = BLWM_IDLE;
            end
          end
        end
        default: begin
          state_nxt = BLWM_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    state_r <= state_nxt;
    cur_addr_r <= cur_addr_nxt;
    beat_r <= beat_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // lane decode: one enable per 9-bit lane

  logic [`BLWM_LANES-1:0] lane_open;

  for (genvar i = 0; i < `BLWM_LANES; i++) begin : g_lane_dec
    // low selector writes the lane, high preserves it
    assign lane_open[i] = ~pins_s.lane_write_select_n[i];
  end

  ////////////////////////////////////////////////////////////////////////
  // lane masking: each low selector opens its own lane

  blwm_beat_s wr;

  always_comb begin
    wr.loc = {beat_addr, beat_idx};
    wr.data = pins_s.data;
    wr.lane_en = '0;
    if (beat_now) begin
      // all low writes the whole word; all high writes nothing
      wr.lane_en = lane_open;
    end
  end

  blwm_lane_mem u_mem (
    .clock(clock),
    .nrst(nrst),
    .wr(wr),
    .rd_en(rd_en),
    .rd_loc(rd_loc),
    .rd_data(rd_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // status outputs

  logic beat_done_r;
  logic beat_done_nxt;
  logic [`BLWM_LANES-1:0] beat_lane_en_r;
  logic [`BLWM_LANES-1:0] beat_lane_en_nxt;
  logic [`BLWM_LOC_W-1:0] beat_loc_r;
  logic [`BLWM_LOC_W-1:0] beat_loc_nxt;

  always_comb begin
    beat_done_nxt = 1'b0;
    beat_lane_en_nxt = beat_lane_en_r;
    beat_loc_nxt = beat_loc_r;
    if (!nrst) begin
      beat_lane_en_nxt = '0;
      beat_loc_nxt = '0;
    end else if (beat_now) begin
      beat_done_nxt = 1'b1;
      beat_lane_en_nxt = wr.lane_en;
      beat_loc_nxt = wr.loc;
    end
  end

  always_ff @(posedge clock) begin
    beat_done_r <= beat_done_nxt;
    beat_lane_en_r <= beat_lane_en_nxt;
    beat_loc_r <= beat_loc_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // refused request: one-cycle pulse

  logic drop_r;
  logic drop_nxt;

  always_comb begin
    drop_nxt = 1'b0;
    if (nrst) begin
      drop_nxt = req_drop;
    end
  end

  always_ff @(posedge clock) begin
    drop_r <= drop_nxt;
  end

  assign write_busy = (state_r == BLWM_BURST);
  assign write_pending = pend_v_r;
  assign beat_done = beat_done_r;
  assign beat_lane_en = beat_lane_en_r;
  assign beat_loc = beat_loc_r;
  assign request_dropped = drop_r;

endmodule

`default_nettype wire
